// ===== ssc_top.sv
`timescale 1ns/1ns
// Behaviour
// - a word is 22 bits: 18 data bits then a 4-bit address.
// - bits are taken only while the enable is low; host keeps it low.
// - data is sampled on each shift clock rising edge while enabled.
// - enable rising edge copies the word into the addressed register.
// - with enable high, clock and data are ignored; word holds.
// - surplus leading bits are dropped; last 22 bits are committed.
// - exactly one high-band loop is active: the last one programmed, upper after reset.
// - a loop self-tunes on power-up and on each new frequency write.
// - power-up comes from the powerdown pin or a serial power write.
// - IF output divider ratio is one, two, four or eight.
// - power bits both one power the loops up; both zero, down.
// - writing a high-band loop's R or N divider selects that loop.
// - self-tuning lasts 13 update periods, then the loop takes over.
module ssc_top (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // serial port pins and powerdown pin
    input wire logic serialClk,
    input wire logic serial_enable_n,
    input wire logic serial_in_line,
    input wire logic powerdown_pin_n,
    // loop timing from the analog side, sys_clk pulses
    input wire logic pdUpdate,
    input wire logic ifVcoTick,
    // loop status
    output logic upperBandActive,
    output logic lowerBandActive,
    output logic rfPowered,
    output logic ifPowered,
    output logic [2:0] tuneActive,
    output logic [2:0] loopControl,
    // selected dividers
    output logic [ssc_pkg::DATA_W-1:0] activeNDivider,
    output logic [ssc_pkg::DATA_W-1:0] activeRDivider,
    // divided IF output
    output logic [1:0] ifDivSelect,
    output logic ifDivPulse
);
    typedef struct packed {
        logic enSync0;
        logic enSync1;
        logic enPrev;
        logic pdSync0;
        logic pdSync1;
        logic [ssc_pkg::REG_COUNT-1:0][ssc_pkg::DATA_W-1:0] regs;
        logic upperActive;
        logic [2:0] prevPowered;
        logic [2:0] tuning;
        logic [2:0][3:0] tuneCnt;
        logic [2:0] ifDivCnt;
        logic ifDivPulse;
    } ssc_core_t;

    function automatic logic [1:0] loopOf(input logic [3:0] addr);
        case (addr)
            ssc_pkg::UPPER_N_ADDR, ssc_pkg::UPPER_R_ADDR: begin
                loopOf = ssc_pkg::LOOP_UPPER;
            end
            ssc_pkg::LOWER_N_ADDR, ssc_pkg::LOWER_R_ADDR: begin
                loopOf = ssc_pkg::LOOP_LOWER;
            end
            ssc_pkg::MID_N_ADDR, ssc_pkg::MID_R_ADDR: begin
                loopOf = ssc_pkg::LOOP_MID;
            end
            default: begin
                loopOf = ssc_pkg::LOOP_NONE;
            end
        endcase
    endfunction : loopOf

    ssc_core_t s;
    ssc_core_t next_s;
    ssc_link_if link ();

    logic commit;
    logic [ssc_pkg::ADDR_W-1:0] commitAddr;
    logic [ssc_pkg::DATA_W-1:0] commitData;
    logic [1:0] commitLoop;
    logic [ssc_pkg::DATA_W-1:0] powerReg;
    logic [ssc_pkg::DATA_W-1:0] mainReg;
    logic [2:0] loopOn;
    logic [3:0] ifRatioLast;

    assign link.serialClk = serialClk;
    assign link.serialEnableN = serial_enable_n;
    assign link.serialInLine = serial_in_line;

    ssc_shift_port i_ssc_shift_port (
        .rst(rst),
        .link(link.shifter)
    );

    // the word is read only after the synchronised enable rise, when the
    // link side is frozen; enable must stay high a few sys_clk cycles
    assign commit = s.enSync1 & ~s.enPrev;
    assign commitAddr = link.shiftWord[ssc_pkg::ADDR_LSB +: ssc_pkg::ADDR_W];
    assign commitData = link.shiftWord[ssc_pkg::DATA_LSB +: ssc_pkg::DATA_W];
    assign commitLoop = loopOf(commitAddr);
    assign powerReg = s.regs[ssc_pkg::POWER_ADDR];
    assign mainReg = s.regs[ssc_pkg::MAIN_CFG_ADDR];

    // both high-band loops share one power bit; the pin overrides all
    assign loopOn[0] = s.pdSync1 & powerReg[ssc_pkg::HIGH_LOOP_POWER_BIT];
    assign loopOn[1] = loopOn[0];
    assign loopOn[2] = s.pdSync1 & powerReg[ssc_pkg::MID_LOOP_POWER_BIT];

    assign ifDivSelect = mainReg[ssc_pkg::IF_DIV_LSB +: ssc_pkg::IF_DIV_W];
    assign ifRatioLast = 4'((4'h1 << ifDivSelect) - 4'h1);

    always_comb begin
        next_s = s;
        next_s.enSync0 = serial_enable_n;
        next_s.enSync1 = s.enSync0;
        next_s.enPrev = s.enSync1;
        next_s.pdSync0 = powerdown_pin_n;
        next_s.pdSync1 = s.pdSync0;
        if (commit) begin
            next_s.regs[commitAddr] = commitData;
            if (commitLoop == ssc_pkg::LOOP_UPPER) begin
                next_s.upperActive = 1'b1;
            end else if (commitLoop == ssc_pkg::LOOP_LOWER) begin
                next_s.upperActive = 1'b0;
            end
        end
        for (int i = 0; i < 3; i++) begin
            next_s.prevPowered[i] = loopOn[i];
            if (!loopOn[i]) begin
                next_s.tuning[i] = 1'b0;
                next_s.tuneCnt[i] = 4'h0;
            end else if (!s.prevPowered[i] ||
                         (commit && commitLoop == 2'(i))) begin
                next_s.tuning[i] = 1'b1;
                next_s.tuneCnt[i] = 4'h0;
            end else if (s.tuning[i] && pdUpdate) begin
                if (s.tuneCnt[i] == ssc_pkg::TUNE_PERIODS - 4'h1) begin
                    next_s.tuning[i] = 1'b0;
                end else begin
                    next_s.tuneCnt[i] = s.tuneCnt[i] + 4'h1;
                end
            end
        end
        next_s.ifDivPulse = 1'b0;
        if (ifVcoTick) begin
            if ({1'b0, s.ifDivCnt} >= ifRatioLast) begin
                next_s.ifDivCnt = 3'h0;
                next_s.ifDivPulse = 1'b1;
            end else begin
                next_s.ifDivCnt = s.ifDivCnt + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '{enSync0: 1'b1, enSync1: 1'b1, enPrev: 1'b1,
                   pdSync0: 1'b0, pdSync1: 1'b0,
                   regs: {ssc_pkg::REG_COUNT{ssc_pkg::REG_RESET}},
                   upperActive: 1'b1, prevPowered: 3'h0, tuning: 3'h0,
                   tuneCnt: 12'h000, ifDivCnt: 3'h0, ifDivPulse: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // one-hot by construction: there is never a state with neither active
    assign upperBandActive = s.upperActive;
    assign lowerBandActive = ~s.upperActive;
    assign rfPowered = loopOn[0];
    assign ifPowered = loopOn[2];
    assign tuneActive = s.tuning;
    assign loopControl = loopOn & ~s.tuning;
    assign activeNDivider = s.upperActive ? s.regs[ssc_pkg::UPPER_N_ADDR]
                                          : s.regs[ssc_pkg::LOWER_N_ADDR];
    assign activeRDivider = s.upperActive ? s.regs[ssc_pkg::UPPER_R_ADDR]
                                          : s.regs[ssc_pkg::LOWER_R_ADDR];
    assign ifDivPulse = s.ifDivPulse;

    a_commit_store: assert property (@(posedge sys_clk) disable iff (rst)
        commit |=> s.regs[$past(commitAddr)] == $past(commitData))
        else $error("committed word not stored");
    a_regs_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !commit |=> $stable(s.regs))
        else $error("register changed without a commit");
    a_loop_select: assert property (@(posedge sys_clk) disable iff (rst)
        commit && commitLoop == ssc_pkg::LOOP_LOWER |=>
            lowerBandActive && !upperBandActive)
        else $error("lower loop not selected after its write");
    a_one_active: assert property (@(posedge sys_clk) disable iff (rst)
        upperBandActive != lowerBandActive)
        else $error("high-band selection not one-hot");
    a_power_write: assert property (@(posedge sys_clk) disable iff (rst)
        commit && commitAddr == ssc_pkg::POWER_ADDR &&
        commitData[ssc_pkg::HIGH_LOOP_POWER_BIT] &&
        commitData[ssc_pkg::MID_LOOP_POWER_BIT] && s.pdSync1 && s.pdSync0
        && !rfPowered && !ifPowered
        |=> rfPowered && ifPowered ##1 tuneActive == 3'h7)
        else $error("power-up write did not power and tune loops");
    a_tune_start: assert property (@(posedge sys_clk) disable iff (rst)
        commit && commitLoop == ssc_pkg::LOOP_MID && ifPowered && s.pdSync0
        && !(commitAddr == ssc_pkg::POWER_ADDR)
        |=> tuneActive[2] && s.tuneCnt[2] == 4'h0)
        else $error("frequency write did not restart tuning");
    a_pin_powerup: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(s.pdSync1) && powerReg[ssc_pkg::MID_LOOP_POWER_BIT] && !commit
        |=> tuneActive[2])
        else $error("pin release did not start tuning");
    a_tune_length: assert property (@(posedge sys_clk) disable iff (rst)
        tuneActive[0] && pdUpdate && s.tuneCnt[0] == 4'hc && loopOn[0] &&
        !commit |=> !tuneActive[0] && loopControl[0])
        else $error("tuning did not end after 13 periods");
    a_if_div_one: assert property (@(posedge sys_clk) disable iff (rst)
        ifVcoTick && ifDivSelect == 2'h0 |=> ifDivPulse)
        else $error("divide by one missed a tick");
endmodule : ssc_top

// ===== ssc_pkg.sv
package ssc_pkg;
    // serial word layout, shifted in most significant bit first
    localparam int WORD_W = 22;
    localparam int DATA_W = 18;
    localparam int ADDR_W = 4;
    localparam int ADDR_LSB = 0;
    localparam int DATA_LSB = 4;
    localparam int REG_COUNT = 16;

    // register addresses
    localparam logic [3:0] MAIN_CFG_ADDR = 4'h0;
    localparam logic [3:0] POWER_ADDR = 4'h2;
    localparam logic [3:0] UPPER_N_ADDR = 4'h3;
    localparam logic [3:0] LOWER_N_ADDR = 4'h4;
    localparam logic [3:0] MID_N_ADDR = 4'h5;
    localparam logic [3:0] UPPER_R_ADDR = 4'h6;
    localparam logic [3:0] LOWER_R_ADDR = 4'h7;
    localparam logic [3:0] MID_R_ADDR = 4'h8;

    // field positions
    localparam int MID_LOOP_POWER_BIT = 0;
    localparam int HIGH_LOOP_POWER_BIT = 1;
    localparam int IF_DIV_LSB = 10;
    localparam int IF_DIV_W = 2;

    // loop indices
    localparam logic [1:0] LOOP_UPPER = 2'h0;
    localparam logic [1:0] LOOP_LOWER = 2'h1;
    localparam logic [1:0] LOOP_MID = 2'h2;
    localparam logic [1:0] LOOP_NONE = 2'h3;

    // reset values and counts
    localparam logic [WORD_W-1:0] SHIFT_RESET = 22'h00_0000;
    localparam logic [DATA_W-1:0] REG_RESET = 18'h0_0000;
    localparam logic [3:0] TUNE_PERIODS = 4'hd;
endpackage : ssc_pkg

// ===== ssc_link_if.sv
`timescale 1ns/1ns
interface ssc_link_if;
    logic serialClk;
    logic serialEnableN;
    logic serialInLine;
    logic [ssc_pkg::WORD_W-1:0] shiftWord;

    modport shifter (
        input serialClk,
        input serialEnableN,
        input serialInLine,
        output shiftWord
    );
    modport core (
        output serialClk,
        output serialEnableN,
        output serialInLine,
        input shiftWord
    );
endinterface : ssc_link_if

// ===== ssc_shift_port.sv
`timescale 1ns/1ns
module ssc_shift_port (
    // reset, asserted with no clock
    input wire logic rst,
    // link pins and captured word
    ssc_link_if.shifter link
);
    typedef struct packed {
        logic [ssc_pkg::WORD_W-1:0] shiftWord;
    } ssc_shift_t;

    ssc_shift_t s;
    ssc_shift_t next_s;

    always_comb begin
        next_s = s;
        // older bits fall off the top, so only the last word survives
        if (!link.serialEnableN) begin
            next_s.shiftWord = {s.shiftWord[ssc_pkg::WORD_W-2:0],
                                link.serialInLine};
        end
    end

    always_ff @(posedge link.serialClk or posedge rst) begin
        if (rst) begin
            s <= '{shiftWord: ssc_pkg::SHIFT_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign link.shiftWord = s.shiftWord;

    a_shift_hold: assert property (@(posedge link.serialClk) disable iff (rst)
        $past(link.serialEnableN) |-> s.shiftWord == $past(s.shiftWord))
        else $error("shift word changed while disabled");
    a_shift_take: assert property (@(posedge link.serialClk) disable iff (rst)
        !link.serialEnableN |=> s.shiftWord[0] == $past(link.serialInLine))
        else $error("serial bit not captured");
    a_shift_move: assert property (@(posedge link.serialClk) disable iff (rst)
        !link.serialEnableN |=>
            s.shiftWord[ssc_pkg::WORD_W-1:1] ==
            $past(s.shiftWord[ssc_pkg::WORD_W-2:0]))
        else $error("shift word did not advance");
endmodule : ssc_shift_port

// ===== ssc_host_model.sv
`timescale 1ns/1ns
module ssc_host_model (
    // serial pins toward the device
    output logic serialClk,
    output logic serialEnableN,
    output logic serialInLine
);
    initial begin
        serialClk = 1'b0;
        serialEnableN = 1'b1;
        serialInLine = 1'b0;
    end

    // link clock runs inside frames and for two stray cycles after each, 32 ns period
    task automatic send_word(input logic [25:0] word, input int nBits);
        serialEnableN = 1'b0;
        #16;
        for (int i = nBits - 1; i >= 0; i--) begin
            serialInLine = word[i];
            #16 serialClk = 1'b1;
            #16 serialClk = 1'b0;
        end
        // no clock rise between enable rise and commit
        #16 serialEnableN = 1'b1;
        // released line shows the inverse, never a stale bit
        serialInLine = ~serialInLine;
        #100;
        // stray clocks after the commit must leave the word alone
        repeat (2) begin
            serialInLine = ~serialInLine;
            #16 serialClk = 1'b1;
            #16 serialClk = 1'b0;
        end
    endtask : send_word
endmodule : ssc_host_model

// ===== ssc_top_tb_top.sv
`timescale 1ns/1ns
module ssc_top_tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b0;
    logic serialClk;
    logic serialEnableN;
    logic serialInLine;
    logic powerdownPinN = 1'b1;
    logic pdUpdate = 1'b0;
    logic ifVcoTick = 1'b0;
    logic upperBandActive;
    logic lowerBandActive;
    logic rfPowered;
    logic ifPowered;
    logic [2:0] tuneActive;
    logic [2:0] loopControl;
    logic [ssc_pkg::DATA_W-1:0] activeNDivider;
    logic [ssc_pkg::DATA_W-1:0] activeRDivider;
    logic [1:0] ifDivSelect;
    logic ifDivPulse;
    int mismatches = 0;
    int checkCount = 0;
    int pulseCount = 0;

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (ifDivPulse === 1'b1) pulseCount <= pulseCount + 1;

    ssc_host_model i_ssc_host_model (
        .serialClk(serialClk),
        .serialEnableN(serialEnableN),
        .serialInLine(serialInLine)
    );
    ssc_top i_ssc_top (
        .sys_clk(sys_clk),
        .rst(rst),
        .serialClk(serialClk),
        .serial_enable_n(serialEnableN),
        .serial_in_line(serialInLine),
        .powerdown_pin_n(powerdownPinN),
        .pdUpdate(pdUpdate),
        .ifVcoTick(ifVcoTick),
        .upperBandActive(upperBandActive),
        .lowerBandActive(lowerBandActive),
        .rfPowered(rfPowered),
        .ifPowered(ifPowered),
        .tuneActive(tuneActive),
        .loopControl(loopControl),
        .activeNDivider(activeNDivider),
        .activeRDivider(activeRDivider),
        .ifDivSelect(ifDivSelect),
        .ifDivPulse(ifDivPulse)
    );

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic cycles(int n);
        repeat (n) @(posedge sys_clk);
        // look just after the edge, once its updates have landed
        #1;
    endtask : cycles

    // surplus leading bits carry junk the device must drop
    task automatic write(logic [3:0] addr, logic [17:0] data, int nBits = 22);
        i_ssc_host_model.send_word({4'ha, data, addr}, nBits);
        cycles(8);
    endtask : write

    task automatic pulse_pd(int n);
        repeat (n) begin
            @(posedge sys_clk) pdUpdate <= 1'b1;
            @(posedge sys_clk) pdUpdate <= 1'b0;
        end
    endtask : pulse_pd

    task automatic test_reset;
        check("upper", upperBandActive, 1);
        check("lower", lowerBandActive, 0);
        check("rfpow", rfPowered, 0);
        check("tune", tuneActive, 0);
        check("ndiv", activeNDivider, 0);
    endtask : test_reset

    task automatic test_power_tune;
        write(ssc_pkg::POWER_ADDR, 18'h0_0003);
        check("rfpow", rfPowered, 1);
        check("ifpow", ifPowered, 1);
        check("tune", tuneActive, 3'h7);
        check("ctrl", loopControl, 0);
        pulse_pd(12);
        cycles(1);
        check("tune12", tuneActive, 3'h7);
        pulse_pd(1);
        cycles(2);
        check("tune13", tuneActive, 0);
        check("ctrl13", loopControl, 3'h7);
    endtask : test_power_tune

    task automatic test_select_hold;
        write(ssc_pkg::LOWER_N_ADDR, 18'h2_abcd, 26);
        check("lower", lowerBandActive, 1);
        check("upper", upperBandActive, 0);
        check("ndiv", activeNDivider, 18'h2_abcd);
        check("tune", tuneActive, 3'h2);
        write(ssc_pkg::UPPER_R_ADDR, 18'h1_2345);
        check("upper", upperBandActive, 1);
        check("rdiv", activeRDivider, 18'h1_2345);
        check("ndivu", activeNDivider, 0);
        write(ssc_pkg::LOWER_R_ADDR, 18'h0_0777);
        check("ndivl", activeNDivider, 18'h2_abcd);
    endtask : test_select_hold

    task automatic test_if_divider;
        int start;
        pulse_pd(13);
        for (int code = 0; code < 4; code++) begin
            write(ssc_pkg::MAIN_CFG_ADDR, {6'h00, 2'(code), 10'h000});
            check("ifsel", ifDivSelect, code);
            start = pulseCount;
            repeat (16) begin
                @(posedge sys_clk) ifVcoTick <= 1'b1;
                @(posedge sys_clk) ifVcoTick <= 1'b0;
            end
            cycles(3);
            check("ifcount", pulseCount - start, 16 >> code);
        end
    endtask : test_if_divider

    task automatic test_mid_retune;
        write(ssc_pkg::MID_N_ADDR, 18'h0_1234);
        check("tunemid", tuneActive, 3'h4);
        check("ctrlmid", loopControl, 3'h3);
        check("lowermid", lowerBandActive, 1);
        check("ndivmid", activeNDivider, 18'h2_abcd);
        pulse_pd(13);
        cycles(2);
        check("tunemid13", tuneActive, 0);
    endtask : test_mid_retune

    task automatic test_pin_powerdown;
        @(posedge sys_clk) powerdownPinN <= 1'b0;
        cycles(4);
        check("rfoff", rfPowered, 0);
        check("tuneoff", tuneActive, 0);
        @(posedge sys_clk) powerdownPinN <= 1'b1;
        cycles(4);
        check("rfon", rfPowered, 1);
        check("tuneon", tuneActive, 3'h7);
    endtask : test_pin_powerdown

    task automatic complete_run;
        if (mismatches == 0 && checkCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    // whole run needs well under 100 us
    initial begin
        #500_000;
        mismatches++;
        complete_run();
    end

    initial begin
        // raised at time zero by a nonblocking write so the link-side reset sees an edge
        rst <= 1'b1;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        cycles(2);
        test_reset();
        test_power_tune();
        test_select_hold();
        test_if_divider();
        test_mid_retune();
        test_pin_powerdown();
        complete_run();
    end
endmodule : ssc_top_tb_top
